// [rsc_pkg.sv]
// Constants, encodings and types shared by the reset source controller
package rsc_pkg;

    // Core clock
    localparam int CLK_MHZ = 250;

    // Pin and detector persistence times, in ns
    localparam int PIN_MIN_PULSE_NS  = 500;
    localparam int BOD_PERSIST_HI_NS = 9000;
    localparam int BOD_PERSIST_LO_NS = 21000;

    // Filter counts in core cycles; the pin figure rounds down so a 500 ns pulse always trips
    localparam int PIN_FILT_CYC = (PIN_MIN_PULSE_NS * CLK_MHZ) / 1000;
    localparam int BOD_FILT_HI_CYC = (BOD_PERSIST_HI_NS * CLK_MHZ + 999) / 1000;
    localparam int BOD_FILT_LO_CYC = (BOD_PERSIST_LO_NS * CLK_MHZ + 999) / 1000;
    localparam int POR_FILT_CYC = 1;
    localparam int FILT_W = 13;

    // Start-up time-out lengths in watchdog oscillator cycles
    localparam int TOUT_W             = 17;
    localparam int TOUT_SHORT_CYC     = 8;
    localparam int TOUT_SHORT_BOD_CYC = 32;
    localparam int TOUT_MID_LO_CYC    = 1024;
    localparam int TOUT_MID_HI_CYC    = 4096;
    localparam int TOUT_LONG_LO_CYC   = 16384;
    localparam int TOUT_LONG_HI_CYC   = 65536;

    // Register port
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_CTRL   = 8'h01;

    // Status fields
    localparam int FLAG_W   = 4;
    localparam int BIT_POR  = 0;
    localparam int BIT_PIN  = 1;
    localparam int BIT_BOD  = 2;
    localparam int BIT_WDT  = 3;

    // Control fields
    localparam int CTRL_W    = 2;
    localparam int CTRL_COMPARATOR_BANDGAP_SELECT = 0;
    localparam int CTRL_ADC  = 1;

    // Start-up delay classes picked by the clock select fuses
    typedef enum logic [1:0] {TC_SHORT, TC_MID, TC_LONG} rsc_tout_class_t;

    // Core reset sequencer
    typedef enum logic [1:0] {ST_HOLD, ST_COUNT, ST_RUN} rsc_state_t;

endpackage : rsc_pkg

// [rsc_sync_filter.sv]
// Three-stage synchroniser with a persistence filter for one asynchronous level
`timescale 1ns/1ps
module rsc_sync_filter
    import rsc_pkg::*;
#(
    parameter bit ACT_LOW = 1'b0,
    parameter int CNT_W   = FILT_W
)(
    // Clock and reset
    input  wire logic             clk_sys_i,
    input  wire logic             sys_rst_i,
    // Level from outside the clock domain
    input  wire logic             async_i,
    // Cycles the level must persist
    input  wire logic [CNT_W-1:0] limit_i,
    // Filtered, active-high detection
    output logic                  det_o
);

    typedef struct packed {
        logic             s1;
        logic             s2;
        logic             s3;
        logic             stable;
        logic [CNT_W-1:0] cnt;
        logic             det;
    } rsc_filt_st_t;

    localparam rsc_filt_st_t FILT_RST = '{s1: ACT_LOW, s2: ACT_LOW, s3: ACT_LOW,
                                          stable: ACT_LOW, cnt: '0, det: 1'b0};

    rsc_filt_st_t q_ff;
    rsc_filt_st_t nxt_q;
    logic         active;

    always_comb
    begin
        nxt_q    = q_ff;
        nxt_q.s1 = async_i;
        nxt_q.s2 = q_ff.s1;
        nxt_q.s3 = q_ff.s2;
        // Only the agreed later stages are trusted, never the first flop
        if (q_ff.s2 == q_ff.s3)
        begin
            nxt_q.stable = q_ff.s3;
        end
        active = q_ff.stable ^ ACT_LOW;
        if (!active)
        begin
            // Release is immediate; only assertion is filtered
            nxt_q.cnt = '0;
            nxt_q.det = 1'b0;
        end
        else if ((q_ff.cnt + 1'b1) >= limit_i)
        begin
            nxt_q.det = 1'b1;
        end
        else
        begin
            nxt_q.cnt = q_ff.cnt + 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
        begin
            q_ff <= FILT_RST;
        end
        else
        begin
            q_ff <= nxt_q;
        end
    end

    assign det_o = q_ff.det;

endmodule : rsc_sync_filter

// [rsc_reset_source_controller.sv]
// Reset source combiner, start-up delay timer, reset cause status and reference enable
//
// The implementer's own choices: the plain strobed port and the register addresses.
`timescale 1ns/1ps
module rsc_reset_source_controller
    import rsc_pkg::*;
#(
    parameter int BOD_HI_CYC        = BOD_FILT_HI_CYC,
    parameter int BOD_LO_CYC        = BOD_FILT_LO_CYC,
    parameter int TOUT_SHORT        = TOUT_SHORT_CYC,
    parameter int TOUT_SHORT_BOD    = TOUT_SHORT_BOD_CYC,
    parameter int TOUT_MID_LO       = TOUT_MID_LO_CYC,
    parameter int TOUT_MID_HI       = TOUT_MID_HI_CYC,
    parameter int TOUT_LONG_LO      = TOUT_LONG_LO_CYC,
    parameter int TOUT_LONG_HI      = TOUT_LONG_HI_CYC
)(
    // Clock and reset
    input  wire logic              clk_sys_i,
    input  wire logic              sys_rst_i,
    // Reset sources
    input  wire logic              reset_pin_n_i,
    input  wire logic              poweron_low_i,
    input  wire logic              brownout_detector_low_i,
    input  wire logic              wdt_timeout_i,
    input  wire logic              wdt_osc_i,
    // Fuses, 1 means programmed
    input  wire logic              brownout_enable_fuse_i,
    input  wire logic              brownout_level_fuse_i,
    input  wire logic [3:0]        clock_select_fuses_i,
    // Register port
    input  wire logic [ADDR_W-1:0] reg_addr_i,
    input  wire logic [DATA_W-1:0] reg_wdata_i,
    input  wire logic              reg_wr_i,
    input  wire logic              reg_rd_i,
    output logic      [DATA_W-1:0] reg_rdata_o,
    // Reset and reference outputs
    output logic                   core_rst_o,
    output logic                   wdt_rst_pulse_o,
    output logic                   brownout_threshold_hi_o,
    output logic                   bandgap_en_o
);

    typedef struct packed {
        rsc_state_t        state;
        logic [TOUT_W-1:0] tcnt;
        logic [TOUT_W-1:0] target;
        logic              core_rst;
        logic              osc_s1;
        logic              osc_s2;
        logic              osc_s3;
        logic              osc_lvl;
        logic              osc_prev;
        logic              wdt_in_prev;
        logic              wdt_pulse;
        logic              pin_prev;
        logic              bod_prev;
        logic [FLAG_W-1:0] flags;
        logic [CTRL_W-1:0] ctrl;
        logic [DATA_W-1:0] rdata;
        logic              bgap;
        logic              thr_hi;
    } rsc_st_t;

    localparam rsc_st_t ST_RST = '{state: ST_HOLD, tcnt: '0, target: '0, core_rst: 1'b1,
                                   osc_s1: 1'b0, osc_s2: 1'b0, osc_s3: 1'b0,
                                   osc_lvl: 1'b0, osc_prev: 1'b0, wdt_in_prev: 1'b0,
                                   wdt_pulse: 1'b0, pin_prev: 1'b0, bod_prev: 1'b0,
                                   flags: '0, ctrl: '0, rdata: '0, bgap: 1'b0,
                                   thr_hi: 1'b0};

    rsc_st_t q_ff;
    rsc_st_t nxt_q;

    logic              pin_det;
    logic              bod_det;
    logic              por_det;
    logic              pin_rst;
    logic              bod_rst;
    logic              hold;
    logic              tick;
    logic [FILT_W-1:0] bod_limit;

    // Delay length from the fuses; short class gains the extra margin with brown-out on
    function automatic logic [TOUT_W-1:0] tout_target(input logic [3:0] sel,
                                                      input logic       lvl_hi,
                                                      input logic       bod_en);
        rsc_tout_class_t cls;
        cls = TC_LONG;
        case (sel)
            4'h1, 4'h4, 4'h7, 4'hc, 4'hf: cls = TC_SHORT;
            4'h0, 4'h3, 4'h6, 4'hb, 4'he: cls = TC_MID;
            default:                      cls = TC_LONG;
        endcase
        case (cls)
            TC_SHORT: tout_target = bod_en ? TOUT_W'(TOUT_SHORT_BOD) : TOUT_W'(TOUT_SHORT);
            TC_MID:   tout_target = lvl_hi ? TOUT_W'(TOUT_MID_HI) : TOUT_W'(TOUT_MID_LO);
            default:  tout_target = lvl_hi ? TOUT_W'(TOUT_LONG_HI) : TOUT_W'(TOUT_LONG_LO);
        endcase
    endfunction : tout_target

    // Brown-out persistence depends on the chosen trigger level
    assign bod_limit = brownout_level_fuse_i ? FILT_W'(BOD_HI_CYC) : FILT_W'(BOD_LO_CYC);

    rsc_sync_filter #(
        .ACT_LOW (1'b1),
        .CNT_W   (FILT_W)
    ) u_pin_filt (
        .clk_sys_i (clk_sys_i),
        .sys_rst_i (sys_rst_i),
        .async_i   (reset_pin_n_i),
        .limit_i   (FILT_W'(PIN_FILT_CYC)),
        .det_o     (pin_det)
    );

    rsc_sync_filter #(
        .ACT_LOW (1'b0),
        .CNT_W   (FILT_W)
    ) u_bod_filt (
        .clk_sys_i (clk_sys_i),
        .sys_rst_i (sys_rst_i),
        .async_i   (brownout_detector_low_i),
        .limit_i   (bod_limit),
        .det_o     (bod_det)
    );

    rsc_sync_filter #(
        .ACT_LOW (1'b0),
        .CNT_W   (FILT_W)
    ) u_por_filt (
        .clk_sys_i (clk_sys_i),
        .sys_rst_i (sys_rst_i),
        .async_i   (poweron_low_i),
        .limit_i   (FILT_W'(POR_FILT_CYC)),
        .det_o     (por_det)
    );

    always_comb
    begin
        nxt_q = q_ff;

        // Sources
        pin_rst = pin_det;
        bod_rst = bod_det & brownout_enable_fuse_i;
        hold    = pin_rst | bod_rst | por_det | q_ff.wdt_pulse;

        // Watchdog oscillator sampled as a slow level; its rising edge is one tick
        nxt_q.osc_s1 = wdt_osc_i;
        nxt_q.osc_s2 = q_ff.osc_s1;
        nxt_q.osc_s3 = q_ff.osc_s2;
        if (q_ff.osc_s2 == q_ff.osc_s3)
        begin
            nxt_q.osc_lvl = q_ff.osc_s3;
        end
        nxt_q.osc_prev = q_ff.osc_lvl;
        tick           = q_ff.osc_lvl & ~q_ff.osc_prev;

        // Watchdog time-out becomes exactly one core cycle of reset
        nxt_q.wdt_in_prev = wdt_timeout_i;
        nxt_q.wdt_pulse   = wdt_timeout_i & ~q_ff.wdt_in_prev;

        // Core reset sequencer
        case (q_ff.state)
            ST_HOLD:
            begin
                nxt_q.core_rst = 1'b1;
                if (!hold)
                begin
                    // Last source gone, including the watchdog pulse falling edge
                    nxt_q.state  = ST_COUNT;
                    nxt_q.tcnt   = '0;
                    nxt_q.target = tout_target(clock_select_fuses_i, brownout_level_fuse_i,
                                               brownout_enable_fuse_i);
                end
            end
            ST_COUNT:
            begin
                nxt_q.core_rst = 1'b1;
                if (hold)
                begin
                    nxt_q.state = ST_HOLD;
                end
                else if (tick)
                begin
                    if ((q_ff.tcnt + 1'b1) >= q_ff.target)
                    begin
                        nxt_q.state    = ST_RUN;
                        nxt_q.core_rst = 1'b0;
                    end
                    else
                    begin
                        nxt_q.tcnt = q_ff.tcnt + 1'b1;
                    end
                end
            end
            ST_RUN:
            begin
                if (hold)
                begin
                    // No further delay on the way in: any source past its filter, or the watchdog pulse, acts at once
                    nxt_q.state    = ST_HOLD;
                    nxt_q.core_rst = 1'b1;
                end
            end
            default:
            begin
                nxt_q.state    = ST_HOLD;
                nxt_q.core_rst = 1'b1;
            end
        endcase

        // Cause flags: write zero clears, a new event wins over that clear
        nxt_q.pin_prev = pin_rst;
        nxt_q.bod_prev = bod_rst;
        if (reg_wr_i && (reg_addr_i == OFF_STATUS))
        begin
            nxt_q.flags = q_ff.flags & reg_wdata_i[FLAG_W-1:0];
        end
        if (q_ff.wdt_pulse)
        begin
            nxt_q.flags[BIT_WDT] = 1'b1;
        end
        if (bod_rst && !q_ff.bod_prev)
        begin
            nxt_q.flags[BIT_BOD] = 1'b1;
        end
        if (pin_rst && !q_ff.pin_prev)
        begin
            nxt_q.flags[BIT_PIN] = 1'b1;
        end
        if (por_det)
        begin
            // Power-on dominates the other causes but never clears its own flag
            nxt_q.flags[BIT_WDT] = 1'b0;
            nxt_q.flags[BIT_BOD] = 1'b0;
            nxt_q.flags[BIT_PIN] = 1'b0;
            nxt_q.flags[BIT_POR] = 1'b1;
        end

        // Control register
        if (reg_wr_i && (reg_addr_i == OFF_CTRL))
        begin
            nxt_q.ctrl = reg_wdata_i[CTRL_W-1:0];
        end

        // Read data stands only in the cycle after the strobe
        nxt_q.rdata = '0;
        if (reg_rd_i)
        begin
            case (reg_addr_i)
                OFF_STATUS: nxt_q.rdata = {{(DATA_W-FLAG_W){1'b0}}, q_ff.flags};
                OFF_CTRL:   nxt_q.rdata = {{(DATA_W-CTRL_W){1'b0}}, q_ff.ctrl};
                default:    nxt_q.rdata = '0;
            endcase
        end

        // Reference is kept off unless a user needs it, to save its standing current
        nxt_q.bgap = brownout_enable_fuse_i | q_ff.ctrl[CTRL_COMPARATOR_BANDGAP_SELECT]
                     | q_ff.ctrl[CTRL_ADC];
        nxt_q.thr_hi = brownout_level_fuse_i;
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
        begin
            q_ff <= ST_RST;
        end
        else
        begin
            q_ff <= nxt_q;
        end
    end

    assign reg_rdata_o             = q_ff.rdata;
    assign core_rst_o              = q_ff.core_rst;
    assign wdt_rst_pulse_o         = q_ff.wdt_pulse;
    assign brownout_threshold_hi_o = q_ff.thr_hi;
    assign bandgap_en_o            = q_ff.bgap;

endmodule : rsc_reset_source_controller

// [rsc_chk.sv]
// Port-level assertions for the reset source controller
`timescale 1ns/1ps
module rsc_chk
    import rsc_pkg::*;
#(
    parameter int BOD_LO_CYC = BOD_FILT_LO_CYC
)(
    // Clock and reset
    input wire logic              clk_sys_i,
    input wire logic              sys_rst_i,
    // Sources and fuses
    input wire logic              reset_pin_n_i,
    input wire logic              poweron_low_i,
    input wire logic              brownout_detector_low_i,
    input wire logic              wdt_timeout_i,
    input wire logic              brownout_enable_fuse_i,
    input wire logic              brownout_level_fuse_i,
    // Outputs
    input wire logic [DATA_W-1:0] reg_rdata_o,
    input wire logic              core_rst_o,
    input wire logic              wdt_rst_pulse_o,
    input wire logic              brownout_threshold_hi_o,
    input wire logic              bandgap_en_o
);
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (sys_rst_i);

    // Run lengths of low pin and low supply; saturate so long holds never wrap
    logic [7:0] pin_lo_ff;
    logic [7:0] bod_lo_ff;
    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i || reset_pin_n_i)
            pin_lo_ff <= 8'h00;
        else if (pin_lo_ff != 8'hff)
            pin_lo_ff <= pin_lo_ff + 8'h01;
        if (sys_rst_i || !brownout_detector_low_i || !brownout_enable_fuse_i)
            bod_lo_ff <= 8'h00;
        else if (bod_lo_ff != 8'hff)
            bod_lo_ff <= bod_lo_ff + 8'h01;
    end

    a_pin_low_reset: assert property (pin_lo_ff >= 8'h87 |-> core_rst_o)
        else $error("core reset missing while pin held low");
    a_pin_release_wait: assert property ($fell(core_rst_o) |-> $past(reset_pin_n_i, 16))
        else $error("core released too soon after pin release");
    a_bod_reset: assert property (bod_lo_ff >= BOD_LO_CYC + 10 |-> core_rst_o)
        else $error("core reset missing during brown-out");
    a_por_reset: assert property (poweron_low_i [*8] |-> core_rst_o)
        else $error("core reset missing during power-on detect");
    a_wdt_one_cycle: assert property ($rose(wdt_timeout_i) |=> wdt_rst_pulse_o ##1 !wdt_rst_pulse_o)
        else $error("watchdog reset pulse not one cycle");
    a_wdt_hold_on: assert property (wdt_rst_pulse_o |=> core_rst_o [*8])
        else $error("core not held after watchdog pulse");
    a_rsvd_read_zero: assert property (reg_rdata_o[7:4] == 4'h0)
        else $error("reserved read bits not zero");
    a_bandgap_bod_on: assert property (brownout_enable_fuse_i |=> bandgap_en_o)
        else $error("reference off with brown-out enabled");
    a_level_select: assert property (brownout_level_fuse_i [*2] |-> brownout_threshold_hi_o)
        else $error("threshold select does not follow level fuse");

    c_wdt_pulse: cover property (wdt_rst_pulse_o);
    c_core_release: cover property ($fell(core_rst_o));
    c_bod_long: cover property (bod_lo_ff == 8'h30);
endmodule : rsc_chk

bind rsc_reset_source_controller rsc_chk #(.BOD_LO_CYC(BOD_LO_CYC)) u_rsc_chk (
    .clk_sys_i               (clk_sys_i),
    .sys_rst_i               (sys_rst_i),
    .reset_pin_n_i           (reset_pin_n_i),
    .poweron_low_i           (poweron_low_i),
    .brownout_detector_low_i (brownout_detector_low_i),
    .wdt_timeout_i           (wdt_timeout_i),
    .brownout_enable_fuse_i  (brownout_enable_fuse_i),
    .brownout_level_fuse_i   (brownout_level_fuse_i),
    .reg_rdata_o             (reg_rdata_o),
    .core_rst_o              (core_rst_o),
    .wdt_rst_pulse_o         (wdt_rst_pulse_o),
    .brownout_threshold_hi_o (brownout_threshold_hi_o),
    .bandgap_en_o            (bandgap_en_o)
);

// [rsc_board_model.sv]
// Board reset circuit: holds the reset pin low for a set time, pull-up otherwise
`timescale 1ns/1ps
module rsc_board_model
(
    // Clock
    input  wire logic       clk_sys_i,
    // Press request and hold length in core cycles
    input  wire logic       press_i,
    input  wire logic [9:0] len_i,
    // Reset pin
    output logic            reset_pin_n_o
);
    logic [9:0] left_ff = 10'h000;
    always_ff @(posedge clk_sys_i)
    begin
        if (press_i)
            left_ff <= len_i;
        else if (left_ff != 10'h000)
            left_ff <= left_ff - 10'h001;
    end
    // Pull-up wins as soon as nobody holds the pin down
    assign reset_pin_n_o = (left_ff == 10'h000);
endmodule : rsc_board_model

// [tb_top.sv]
// Self-checking bench for the reset source controller
`timescale 1ns/1ps
module tb_top
    import rsc_pkg::*;
;
    logic              clk_sys_i = 1'b0;
    logic              sys_rst_i, pin_n, por_low, bod_low, wdt_to;
    logic              wdt_osc = 1'b0;
    logic              bod_en, bod_lvl, press, wr, rd, core_rst, wdt_pulse, thr_hi, bg_en;
    logic [3:0]        clock_select_fuses;
    logic [9:0]        plen;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata, rdata;
    int                n_fail = 0;
    int                n_compared = 0;
    int                cyc = 0;
    int                n;
    int                tgt[3] = '{4, 8, 12};
    logic [3:0]        sel[3] = '{4'h1, 4'h0, 4'h2};

    // Only the brown-out-off, low-level delay of each class is shortened; the rest keep their real lengths
    rsc_reset_source_controller #(.BOD_HI_CYC(20), .BOD_LO_CYC(40), .TOUT_SHORT(4),
        .TOUT_MID_LO(8), .TOUT_LONG_LO(12)) dut (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
        .reset_pin_n_i(pin_n), .poweron_low_i(por_low), .brownout_detector_low_i(bod_low),
        .wdt_timeout_i(wdt_to), .wdt_osc_i(wdt_osc), .brownout_enable_fuse_i(bod_en),
        .brownout_level_fuse_i(bod_lvl), .clock_select_fuses_i(clock_select_fuses), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
        .core_rst_o(core_rst), .wdt_rst_pulse_o(wdt_pulse),
        .brownout_threshold_hi_o(thr_hi), .bandgap_en_o(bg_en));

    rsc_board_model u_board (.clk_sys_i(clk_sys_i), .press_i(press), .len_i(plen),
        .reset_pin_n_o(pin_n));

    initial
    begin
        forever #2 clk_sys_i = ~clk_sys_i;
    end

    // Slow watchdog oscillator, eight core cycles a period; hang guard
    always @(posedge clk_sys_i)
    begin
        cyc <= cyc + 1;
        if (cyc % 4 == 3)
            wdt_osc <= ~wdt_osc;
        if (cyc == 20000)
        begin
            n_fail++;
            $display("[ERR] %0t timeout", $time);
            results();
        end
    end

    task automatic results();
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : results

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_sys_i);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk_sys_i);
        rd <= 1'b0;
        @(negedge clk_sys_i);
        chk(rdata, exp);
        // Hand back on a rising edge so the next stimulus lands there
        @(posedge clk_sys_i);
    endtask : rd_chk

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk_sys_i);
        wr <= 1'b0;
    endtask : wr_reg

    task automatic idle(input int k);
        repeat (k) @(posedge clk_sys_i);
    endtask : idle

    // Bounded wait for core release; a hang here counts as a mismatch
    task automatic wait_rel(output int cnt);
        cnt = 0;
        while (core_rst !== 1'b0 && cnt < 3000)
        begin
            @(negedge clk_sys_i);
            cnt++;
        end
        @(posedge clk_sys_i);
        chk({7'h0, cnt < 3000}, 8'h01);
    endtask : wait_rel

    task automatic wdt_fire();
        @(posedge clk_sys_i);
        wdt_to <= 1'b1;
        @(posedge clk_sys_i);
        wdt_to <= 1'b0;
        idle(3);
    endtask : wdt_fire

    initial
    begin
        {sys_rst_i, por_low, bod_low, wdt_to, bod_en, bod_lvl} = 6'h20;
        {press, wr, rd, addr, wdata} = '0;
        clock_select_fuses = 4'h1;
        plen = 10'h0c8;
        idle(3);
        sys_rst_i <= 1'b0;
        wait_rel(n);
        rd_chk(OFF_STATUS, 8'h00);
        @(posedge clk_sys_i);
        press <= 1'b1;
        @(posedge clk_sys_i);
        press <= 1'b0;
        idle(150);
        chk({7'h0, core_rst}, 8'h01);
        idle(60);
        chk({7'h0, core_rst}, 8'h01);
        wait_rel(n);
        rd_chk(OFF_STATUS, 8'h02);
        wdt_fire();
        wait_rel(n);
        rd_chk(OFF_STATUS, 8'h0a);
        wr_reg(OFF_STATUS, 8'hf7);
        rd_chk(OFF_STATUS, 8'h02);
        wdt_fire();
        wait_rel(n);
        por_low <= 1'b1;
        idle(12);
        chk({7'h0, core_rst}, 8'h01);
        por_low <= 1'b0;
        wait_rel(n);
        rd_chk(OFF_STATUS, 8'h01);
        // Brown-out with detection fused off must stay silent
        bod_low <= 1'b1;
        idle(100);
        bod_low <= 1'b0;
        chk({7'h0, core_rst}, 8'h00);
        rd_chk(OFF_STATUS, 8'h01);
        wr_reg(OFF_STATUS, 8'h00);
        rd_chk(OFF_STATUS, 8'h00);
        bod_en <= 1'b1;
        bod_lvl <= 1'b1;
        idle(3);
        chk({6'h0, thr_hi, bg_en}, 8'h03);
        bod_low <= 1'b1;
        idle(10);
        bod_low <= 1'b0;
        idle(10);
        chk({7'h0, core_rst}, 8'h00);
        bod_low <= 1'b1;
        idle(60);
        chk({7'h0, core_rst}, 8'h01);
        bod_low <= 1'b0;
        idle(6);
        chk({7'h0, core_rst}, 8'h01);
        wait_rel(n);
        rd_chk(OFF_STATUS, 8'h04);
        bod_en <= 1'b0;
        bod_lvl <= 1'b0;
        for (int i = 0; i < 4; i++)
        begin
            wr_reg(OFF_CTRL, i[7:0]);
            idle(2);
            chk({7'h0, bg_en}, {7'h0, i != 0});
            rd_chk(OFF_CTRL, i[7:0]);
        end
        wr_reg(8'h05, 8'hff);
        rd_chk(8'h05, 8'h00);
        rd_chk(OFF_STATUS, 8'h04);
        // Delay length per clock select class, timed from the watchdog pulse
        for (int i = 0; i < 3; i++)
        begin
            clock_select_fuses <= sel[i];
            idle(2);
            wdt_fire();
            wait_rel(n);
            chk({7'h0, n + 5 >= (tgt[i] - 1) * 8 && n + 5 <= tgt[i] * 8 + 12}, 8'h01);
        end
        results();
    end
endmodule : tb_top
